// >>> verilog/scan_tap_regs.vh
/*
 * constants of the boundary-scan port: state codes, instruction codes,
 * register widths and reset values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef SCAN_TAP_REGS_VH
`define SCAN_TAP_REGS_VH

// ==========================================================
// controller states
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SHIFT_DR   4'h4
`define ST_EXIT1_DR   4'h5
`define ST_PAUSE_DR   4'h6
`define ST_EXIT2_DR   4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'hA
`define ST_SHIFT_IR   4'hB
`define ST_EXIT1_IR   4'hC
`define ST_PAUSE_IR   4'hD
`define ST_EXIT2_IR   4'hE
`define ST_UPD_IR     4'hF

// ==========================================================
// instructions
`define IR_WIDTH        3
`define INS_EXTEST      3'h0
`define INS_IDCODE      3'h1
`define INS_SAMPLE_Z    3'h2
`define INS_RESERVED    3'h3
`define INS_SAMPLE      3'h4
`define INS_BYPASS      3'h7
`define IR_CAPTURE      2'h1

// ==========================================================
// data registers
`define ID_WIDTH        32
`define ID_VALUE        32'h0000_0001 // arbitrary value, low bit set
`define PIN_WIDTH       8
`define FILL_WIDTH      2
`define BSR_WIDTH       10
`define FIFO_WIDTH      1
`define FIFO_DEPTH      4

`endif

// >>> verilog/scan_fifo.v
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module scan_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_sys,   // system clock
    input  wire             rst_b,     // sync reset, low
    input  wire [WIDTH-1:0] in_data,   // write data
    input  wire             in_valid,  // write request
    output wire             in_ready,  // room left
    output wire [WIDTH-1:0] out_data,  // head word
    output wire             out_valid, // not empty
    input  wire             out_ready  // drain
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // ==========================================================
    // pointers and storage
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push & ~pop)
                count <= count + 1'b1;
            else if (pop & ~push)
                count <= count - 1'b1;
        end
    end
endmodule // scan_fifo

// >>> verilog/scan_tap.v
/*
 * boundary-scan test port of the sram, sampled on the system clock.
 * assumes test clock, mode and data pins arrive asynchronously and
 * that a floating pin reads high at the pad (pull-ups outside).
 */
`timescale 1ns/1ps
`include "scan_tap_regs.vh"

// What this block does
// - standard test port state machine and selection
// - sample on rising, update on falling
// - floating mode select reads as one
// - floating data input shifts ones
// - path chosen by state and instruction
// - data out driven only in shift states
// - five high mode edges reach reset
// - port starts in reset state
// - idle without test clock edges
// - registers shift rising, present falling
// - three bit instruction, loaded when selected
// - instruction acts from idle and data states
// - reset loads identify instruction
// - single flip-flop bypass
// - pin capture plus constant one fillers
// - scan register captures and shifts
// - only three instructions pick scan register
// - 000 extest, 001 identify
// - 010 capture, scan path, outputs float
// - 011 acts as bypass
// - capture loads 01 into instruction
module scan_tap (
    input  wire                  clk_sys,     // system clock
    input  wire                  rst_b,       // sync reset, low
    input  wire                  tck,         // test clock pin
    input  wire                  tms,         // mode select pin
    input  wire                  tdi,         // serial data in pin
    input  wire [`PIN_WIDTH-1:0] pins,        // ram pin levels
    output reg                   tdo,         // serial data out
    output reg                   tdo_oe,      // data out enable
    output reg                   outputs_off, // force ram drivers off
    output reg                   extest_on,   // scan drives outputs
    output reg  [`PIN_WIDTH-1:0] scan_out,    // update latch of scan
    output reg                   fifo_full    // serial fifo full
);
    // ==========================================================
    // synchronisers and edge finding
    reg [1:0] tck_s;
    reg [1:0] tms_s;
    reg [1:0] tdi_s;
    reg [`PIN_WIDTH-1:0] pin_a;
    reg [`PIN_WIDTH-1:0] pin_b;
    reg tck_d;
    wire rise;
    wire fall;

    // only the second stage is read, first stage stays private
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            tck_s <= 2'h0;
            tms_s <= 2'h3;
            tdi_s <= 2'h3;
            pin_a <= {`PIN_WIDTH{1'b0}};
            pin_b <= {`PIN_WIDTH{1'b0}};
            tck_d <= 1'b0;
        end else begin
            tck_s <= {tck_s[0], tck};
            tms_s <= {tms_s[0], tms};
            tdi_s <= {tdi_s[0], tdi};
            pin_a <= pins;
            pin_b <= pin_a;
            tck_d <= tck_s[1];
        end
    end

    assign rise = tck_s[1] & ~tck_d;
    assign fall = ~tck_s[1] & tck_d;

    // ==========================================================
    // controller state machine
    reg [3:0] state;
    reg [3:0] next_state;

    always @* begin
        case (state)
            `ST_RESET:    next_state = tms_s[1] ? `ST_RESET : `ST_IDLE;
            `ST_IDLE:     next_state = tms_s[1] ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR:   next_state = tms_s[1] ? `ST_SEL_IR : `ST_CAP_DR;
            `ST_CAP_DR:   next_state = tms_s[1] ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_SHIFT_DR: next_state = tms_s[1] ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_EXIT1_DR: next_state = tms_s[1] ? `ST_UPD_DR : `ST_PAUSE_DR;
            `ST_PAUSE_DR: next_state = tms_s[1] ? `ST_EXIT2_DR : `ST_PAUSE_DR;
            `ST_EXIT2_DR: next_state = tms_s[1] ? `ST_UPD_DR : `ST_SHIFT_DR;
            `ST_UPD_DR:   next_state = tms_s[1] ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR:   next_state = tms_s[1] ? `ST_RESET : `ST_CAP_IR;
            `ST_CAP_IR:   next_state = tms_s[1] ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_SHIFT_IR: next_state = tms_s[1] ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_EXIT1_IR: next_state = tms_s[1] ? `ST_UPD_IR : `ST_PAUSE_IR;
            `ST_PAUSE_IR: next_state = tms_s[1] ? `ST_EXIT2_IR : `ST_PAUSE_IR;
            `ST_EXIT2_IR: next_state = tms_s[1] ? `ST_UPD_IR : `ST_SHIFT_IR;
            `ST_UPD_IR:   next_state = tms_s[1] ? `ST_SEL_DR : `ST_IDLE;
            default:      next_state = `ST_RESET;
        endcase
    end

    // ==========================================================
    // path selection by current instruction
    reg [`IR_WIDTH-1:0] ir_shift;
    reg [`IR_WIDTH-1:0] ir;
    reg [`ID_WIDTH-1:0] id_reg;
    reg [`BSR_WIDTH-1:0] bsr;
    reg bypass;

    // undefined and reserved codes collapse to the one-bit path
    function [1:0] path_of;
        input [`IR_WIDTH-1:0] code;
        begin
            case (code)
                `INS_EXTEST:   path_of = 2'h2;
                `INS_SAMPLE:   path_of = 2'h2;
                `INS_SAMPLE_Z: path_of = 2'h2;
                `INS_IDCODE:   path_of = 2'h1;
                `INS_RESERVED: path_of = 2'h0;
                default:       path_of = 2'h0;
            endcase
        end
    endfunction

    wire [1:0] path = path_of(ir);
    wire ir_path = (state == `ST_SHIFT_IR);
    wire dr_path = (state == `ST_SHIFT_DR);
    reg  serial_bit;

    always @* begin
        if (ir_path)
            serial_bit = ir_shift[0];
        else if (path == 2'h2)
            serial_bit = bsr[0];
        else if (path == 2'h1)
            serial_bit = id_reg[0];
        else
            serial_bit = bypass;
    end

    // ==========================================================
    // rising edge work: state, capture, shift, update
    // no test clock edge means nothing below moves
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state    <= `ST_RESET;
            ir       <= `INS_IDCODE;
            ir_shift <= `INS_IDCODE;
            id_reg   <= `ID_VALUE;
            bsr      <= {`BSR_WIDTH{1'b1}};
            bypass   <= 1'b0;
        end else if (rise) begin
            state <= next_state;
            case (state)
                `ST_RESET: begin
                    ir       <= `INS_IDCODE;
                    ir_shift <= `INS_IDCODE;
                end
                `ST_CAP_IR:
                    ir_shift <= {ir_shift[`IR_WIDTH-1:2],
                                 `IR_CAPTURE};
                `ST_SHIFT_IR:
                    ir_shift <= {tdi_s[1],
                                 ir_shift[`IR_WIDTH-1:1]};
                `ST_UPD_IR:
                    ir <= ir_shift;
                `ST_CAP_DR: begin
                    bypass <= 1'b0;
                    if (path == 2'h1)
                        id_reg <= `ID_VALUE;
                    if (path == 2'h2)
                        bsr <= {{`FILL_WIDTH{1'b1}}, pin_b};
                end
                `ST_SHIFT_DR: begin
                    bypass <= tdi_s[1];
                    if (path == 2'h1)
                        id_reg <= {tdi_s[1], id_reg[`ID_WIDTH-1:1]};
                    if (path == 2'h2)
                        bsr <= {tdi_s[1], bsr[`BSR_WIDTH-1:1]};
                end
                default: ;
            endcase
            // any rise that lands in reset reloads the instruction,
            // so the float/extest modes drop on the very next fall
            if (next_state == `ST_RESET) begin
                ir       <= `INS_IDCODE;
                ir_shift <= `INS_IDCODE;
            end
        end
    end

    // ==========================================================
    // falling edge work: every test output except fifo_full moves here
    wire [`PIN_WIDTH-1:0] fifo_out;
    wire fifo_valid;
    wire fifo_ready;
    wire shift_now = ir_path | dr_path;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            tdo         <= 1'b0;
            tdo_oe      <= 1'b0;
            outputs_off <= 1'b0;
            extest_on   <= 1'b0;
            scan_out    <= {`PIN_WIDTH{1'b0}};
            fifo_full   <= 1'b0;
        end else begin
            fifo_full <= ~fifo_ready;
            if (fall) begin
                tdo_oe      <= shift_now;
                tdo         <= shift_now ? serial_bit : 1'b0;
                outputs_off <= (ir == `INS_SAMPLE_Z);
                extest_on   <= (ir == `INS_EXTEST);
                if (state == `ST_UPD_DR && path == 2'h2)
                    scan_out <= bsr[`PIN_WIDTH-1:0];
            end
        end
    end

    // ==========================================================
    // serial bit log: each shifted-out bit passes a small fifo,
    // drained once per falling edge, so it never holds more than one bit
    scan_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (2)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_data   (serial_bit),
        .in_valid  (rise & shift_now),
        .in_ready  (fifo_ready),
        .out_data  (fifo_out[0]),
        .out_valid (fifo_valid),
        .out_ready (fall)
    );
    assign fifo_out[`PIN_WIDTH-1:1] = {(`PIN_WIDTH-1){1'b0}};
endmodule // scan_tap

// >>> tb/scan_tap_props.sv
/* checker of the scan port, bound to scan_tap.
   assumes tck moves only on clk_sys edges. */
`timescale 1ns/1ps
`include "scan_tap_regs.vh"
module scan_tap_props (
    input wire                  clk_sys,     // clock
    input wire                  rst_b,       // reset, low
    input wire                  tck,         // test clock
    input wire                  tms,         // mode
    input wire                  tdi,         // data in
    input wire [`PIN_WIDTH-1:0] pins,        // pin levels
    input wire                  tdo,         // data out
    input wire                  tdo_oe,      // out enable
    input wire                  outputs_off, // drivers off
    input wire                  extest_on,   // scan drives
    input wire [`PIN_WIDTH-1:0] scan_out,    // scan latch
    input wire                  fifo_full    // fifo full
);
    logic       tck_q;
    logic [2:0] age;
    logic [3:0] still;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // clocks since tck fell, and since tck last moved (saturating)
    always @(posedge clk_sys) begin
        tck_q <= tck;
        if (!rst_b) begin
            age   <= 3'h7;
            still <= 4'h0;
        end else begin
            age   <= (tck_q && !tck) ? 3'h0 : age + {2'h0, age != 3'h7};
            still <= (tck_q != tck) ? 4'h0 : still + {3'h0, still != 4'hF};
        end
    end
    // two sync flops plus detect: outputs move 2..4 clocks after fall
    a_tdo_on_fall: assert property ($changed(tdo) |-> age <= 3'h4)
        else $error("tdo moved away from a tck fall");
    a_oe_on_fall: assert property ($changed(tdo_oe) |-> age <= 3'h4)
        else $error("tdo_oe moved away from a tck fall");
    a_mode_on_fall: assert property
        ($changed({outputs_off, extest_on}) |-> age <= 3'h4)
        else $error("mode outputs moved away from a tck fall");
    a_scan_on_fall: assert property ($changed(scan_out) |-> age <= 3'h4)
        else $error("scan_out moved away from a tck fall");
    a_tdo_quiet_off: assert property (!tdo_oe |-> !tdo)
        else $error("tdo high while not enabled");
    a_modes_apart: assert property (!(outputs_off && extest_on))
        else $error("float and extest both active");
    a_still_quiet: assert property (still >= 4'h8 |->
        $stable({tdo, tdo_oe, outputs_off, extest_on, scan_out}))
        else $error("outputs moved with tck still");
    a_reset_clears: assert property (disable iff (1'b0) !rst_b |=>
        {tdo, tdo_oe, outputs_off, extest_on} == 4'h0)
        else $error("outputs not cleared by reset");
    a_fifo_not_full: assert property (!fifo_full)
        else $error("serial bit fifo filled up");
    c_shift: cover property ($rose(tdo_oe));
    c_float: cover property ($rose(outputs_off));
    c_extest: cover property ($rose(extest_on));
endmodule // scan_tap_props
bind scan_tap scan_tap_props u_props (.clk_sys(clk_sys), .rst_b(rst_b),
    .tck(tck), .tms(tms), .tdi(tdi), .pins(pins), .tdo(tdo),
    .tdo_oe(tdo_oe), .outputs_off(outputs_off), .extest_on(extest_on),
    .scan_out(scan_out), .fifo_full(fifo_full));

// >>> tb/scan_ctrl_model.sv
/* boundary-scan controller model: test clock, mode, data in.
   assumes clk_sys paces it; mode and data lines idle high as if pulled up. */
`timescale 1ns/1ps
module scan_ctrl_model (
    input  wire  clk_sys, // pacing clock
    input  wire  tdo,     // data from port
    output logic tck,     // still low between frames
    output logic tms,     // mode select
    output logic tdi      // data to port
);
    // ==========================================================
    // one tck period is 8 clk_sys: 160 ns, 4 high and 4 low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // data set 2 clocks before rise; tdo read mid-high, safe after fall
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge clk_sys);
        tms <= m;
        tdi <= d;
        repeat (2) @(posedge clk_sys);
        tck <= 1'b1;
        repeat (2) @(posedge clk_sys);
        q = tdo;
        repeat (2) @(posedge clk_sys);
        tck <= 1'b0;
        @(posedge clk_sys);
    endtask
    // five high mode edges, then into idle
    task automatic reset5();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        // the port senses the last fall 3 clocks late; let it settle
        repeat (3) @(posedge clk_sys);
    endtask
    // idle -> capture -> shift n bits lsb first -> update -> idle
    task automatic shift(input logic ir, input int n,
                         input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = 32'h0000_0000;
        step(1'b1, 1'b1, q);
        if (ir)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        tms <= 1'b1;
        tdi <= 1'b1;
        // outputs follow the sensed fall; wait before anyone looks
        repeat (3) @(posedge clk_sys);
    endtask
endmodule // scan_ctrl_model

// >>> tb/scan_tap_tb.sv
/* self-checking bench of scan_tap, driven by scan_ctrl_model.
   assumes 50 MHz clk_sys and the fixed pin level 8'hA5. */
`timescale 1ns/1ps
module scan_tap_tb;
    typedef struct packed {
        logic [2:0]  code;
        logic [31:0] dr;
        logic        off;
        logic        ext;
    } row_t;
    logic        clk_sys;
    logic        rst_b;
    logic [7:0]  pins;
    wire         tck, tms, tdi, tdo, tdo_oe, outputs_off, extest_on;
    wire  [7:0]  scan_out;
    wire         fifo_full;
    logic [31:0] got;
    logic        q;
    row_t        rows [8];
    int          err_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    scan_tap u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .tck(tck),
        .tms(tms), .tdi(tdi), .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe),
        .outputs_off(outputs_off), .extest_on(extest_on),
        .scan_out(scan_out), .fifo_full(fifo_full));
    scan_ctrl_model u_ctrl (.clk_sys(clk_sys), .tdo(tdo), .tck(tck),
        .tms(tms), .tdi(tdi));
    // ==========================================================
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // hang guard: a full run needs about 4240 clocks
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, act);
        check_count++;
        if (act !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, act);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // shift-in 5A00_0000: bypass shows it one bit late, scan keeps pins
    initial begin
        rows = '{'{3'h0, 32'h0000_03A5, 1'h0, 1'h1},
                 '{3'h1, 32'h0000_0001, 1'h0, 1'h0},
                 '{3'h2, 32'h0000_03A5, 1'h1, 1'h0},
                 '{3'h3, 32'hB400_0000, 1'h0, 1'h0},
                 '{3'h4, 32'h0000_03A5, 1'h0, 1'h0},
                 '{3'h5, 32'hB400_0000, 1'h0, 1'h0},
                 '{3'h6, 32'hB400_0000, 1'h0, 1'h0},
                 '{3'h7, 32'hB400_0000, 1'h0, 1'h0}};
        rst_b <= 1'b0;
        pins <= 8'hA5;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        u_ctrl.reset5();
        u_ctrl.shift(1'b0, 32, 32'h5A00_0000, got);
        chk("id at start", 32'h0000_0001, got);
        foreach (rows[i]) begin
            u_ctrl.shift(1'b1, 3, {29'h0, rows[i].code}, got);
            chk("ir capture", 32'h0000_0001, got & 32'h0000_0003);
            chk("outputs_off", {31'h0, rows[i].off},
                {31'h0, outputs_off});
            chk("extest_on", {31'h0, rows[i].ext}, {31'h0, extest_on});
            chk("tdo_oe idle", 32'h0, {31'h0, tdo_oe});
            u_ctrl.shift(1'b0, 32, 32'h5A00_0000, got);
            chk("data path", rows[i].dr, got);
            if (rows[i].dr == 32'h0000_03A5)
                chk("scan_out", 32'h0000_0068, {24'h0, scan_out});
        end
        // mode-select reset from the first bit of a data shift
        u_ctrl.shift(1'b1, 3, 32'h0000_0002, got);
        u_ctrl.step(1'b1, 1'b1, q);
        u_ctrl.step(1'b0, 1'b1, q);
        u_ctrl.step(1'b0, 1'b1, q);
        repeat (3) @(posedge clk_sys);
        chk("tdo_oe in shift", 32'h1, {31'h0, tdo_oe});
        chk("tdo first scan bit", 32'h1, {31'h0, tdo});
        u_ctrl.reset5();
        chk("off after reset5", 32'h0, {31'h0, outputs_off});
        u_ctrl.shift(1'b0, 32, 32'h5A00_0000, got);
        chk("id after reset5", 32'h0000_0001, got);
        // system reset with extest active
        u_ctrl.shift(1'b1, 3, 32'h0000_0000, got);
        chk("extest before", 32'h1, {31'h0, extest_on});
        rst_b <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("extest after reset", 32'h0, {31'h0, extest_on});
        u_ctrl.reset5();
        u_ctrl.shift(1'b0, 32, 32'h5A00_0000, got);
        chk("id after reset", 32'h0000_0001, got);
        chk("fifo_full", 32'h0, {31'h0, fifo_full});
        tally_and_finish();
    end
endmodule // scan_tap_tb
